// ### inc/hbwe_params.svh
// Register offsets, field positions and codes for the host bus write error unit
`ifndef HBWE_PARAMS_SVH
`define HBWE_PARAMS_SVH
`define HBWE_OFS_FAIL_HI     8'h00
`define HBWE_OFS_FAIL_LO     8'h04
`define HBWE_OFS_EVENT       8'h08
`define HBWE_OFS_EVCLR       8'h0c
`define HBWE_OFS_CTX         8'h10
`define HBWE_OFS_CTXCLR      8'h14
`define HBWE_OFS_STATUS      8'h18
`define HBWE_EVT_NONE        5'h00
`define HBWE_EVT_DATA_WRITE  5'h05
`define HBWE_EVT_OVERRUN     5'h07
`define HBWE_EVT_DATA_READ   5'h04
`define HBWE_RESP_DATA_ERROR 4'h5
`define HBWE_RESP_COMPLETE   4'h0
`define HBWE_ACK_COMPLETE    4'h1
`define HBWE_ACK_PENDING     4'h2
`define HBWE_ACK_BUSY        4'h4
`define HBWE_ACK_DATA_ERROR  4'hd
`define HBWE_BIT_PWF         0
`define HBWE_QDEPTH          4
`endif

// ### inc/hbwe_pkg.sv
// Types for the host bus write error unit
package hbwe_pkg;
  typedef struct packed {
    logic        valid;
    logic [15:0] requester_bus_node;
    logic [47:0] dest_offset;
  } hbwe_fail_type;
  typedef struct packed {
    logic       dead;
    logic [4:0] event_code;
  } hbwe_ctx_type;
  typedef enum logic [1:0] {
    HBWE_RX_ASYNC,
    HBWE_RX_PPB,
    HBWE_RX_FILL
  } hbwe_rxmode_type;
  typedef enum logic [1:0] {
    HBWE_SV_IDLE,
    HBWE_SV_WRITE,
    HBWE_SV_SEND
  } hbwe_sv_type;
  typedef enum logic [1:0] {
    HBWE_PR_IDLE,
    HBWE_PR_SENDING,
    HBWE_PR_WAITACK
  } hbwe_pr_type;
endpackage

// ### hw/hbwe_unit.sv
// Host bus write error handling unit with Avalon-MM register slave
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`include "hbwe_params.svh"
`default_nettype none
module hbwe_unit
  import hbwe_pkg::*;
#(
  parameter int QDEPTH = `HBWE_QDEPTH
) (
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire logic [7:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  output logic      [1:0]              avs_response,
  input  wire logic                    sv_request,
  input  wire logic                    sv_mem_done,
  input  wire logic                    sv_mem_error,
  output logic                         sv_mem_start,
  output logic                         sv_load_packet,
  output logic      [4:0]              sv_event_code,
  output logic                         sv_event_valid,
  input  wire logic [1:0]              rx_ctx_sel,
  input  wire logic                    rx_bus_error,
  input  wire logic                    rx_fifo_overrun,
  input  wire logic [31:0]             rx_desc_addr,
  output logic      [31:0]             descriptor_pointer_reg,
  output logic                         rx_flush_ctx,
  output logic                         rx_flush_packet,
  output logic                         rx_backout,
  output logic                         rx_update_status,
  input  wire logic                    pr_start,
  input  wire logic                    pr_read_error,
  input  wire logic                    pr_underrun,
  input  wire logic                    pr_first_sent,
  input  wire logic                    pr_ack_valid,
  input  wire logic [3:0]              pr_ack_code,
  output logic                         pr_send,
  output logic                         pr_stop_tx,
  output logic      [3:0]              pr_resp_code,
  input  wire logic                    pw_request,
  input  wire logic [15:0]             pw_requester_bus_node,
  input  wire logic [47:0]             pw_dest_offset,
  input  wire logic                    pw_mem_done,
  input  wire logic                    pw_mem_error,
  output logic                         pw_ack_valid,
  output logic      [3:0]              pw_ack_code,
  output logic                         pw_fifo_drop,
  output logic                         deferred_write_failure_flag
);
  import hbwe_pkg::*;

  localparam int QW = $clog2(QDEPTH + 1);

  typedef struct packed {
    logic [1:0]         rst_sync;
    hbwe_fail_type [QDEPTH-1:0] queue;
    logic [QW-1:0]      fail_cnt;
    logic [QW-1:0]      posted_cnt;
    logic               flag;
    logic [15:0]        show_node;
    logic [47:0]        show_offset;
    hbwe_ctx_type [2:0] ctx;
    logic [31:0]        desc_ptr;
    hbwe_sv_type        sv_st;
    logic [4:0]         sv_evt;
    logic               sv_evt_v;
    hbwe_pr_type        pr_st;
    logic               pr_bus_err;
    logic [3:0]         pr_code;
    logic               pr_stop;
    logic [3:0]         ack_code;
    logic               ack_v;
    logic               drop;
    logic [3:0]         rx_pulses;
    logic [31:0]        rdata;
    logic               rd_done;
  } hbwe_state_type;

  hbwe_state_type s_q, s_d;
  logic rst_n;
  assign rst_n = s_q.rst_sync[1];

  // Register address check, used by read and write paths
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a <= `HBWE_OFS_STATUS) && (a[1:0] == 2'b00);
  endfunction

  // Next-state logic for all sub-blocks
  always_comb begin
    s_d = s_q;
    s_d.rst_sync = {s_q.rst_sync[0], 1'b1};
    s_d.sv_evt_v = 1'b0;
    s_d.ack_v = 1'b0;
    s_d.drop = 1'b0;
    s_d.rx_pulses = 4'h0;
    s_d.pr_stop = 1'b0;
    s_d.rd_done = 1'b0;

    // Store-value write before packet load
    case (s_q.sv_st)
      HBWE_SV_IDLE: if (sv_request) s_d.sv_st = HBWE_SV_WRITE;
      HBWE_SV_WRITE: begin
        if (sv_mem_error) begin
          s_d.sv_evt = `HBWE_EVT_DATA_WRITE;
          s_d.sv_evt_v = 1'b1;
          s_d.sv_st = HBWE_SV_IDLE; // context keeps running
        end else if (sv_mem_done) begin
          s_d.sv_st = HBWE_SV_SEND; // load only after write
        end
      end
      HBWE_SV_SEND: s_d.sv_st = HBWE_SV_IDLE;
      default: s_d.sv_st = HBWE_SV_IDLE;
    endcase

    // Receive write errors per context mode
    if (rx_bus_error || rx_fifo_overrun) begin
      if (rx_ctx_sel == HBWE_RX_PPB) begin
        s_d.ctx[rx_ctx_sel].event_code = rx_fifo_overrun ? `HBWE_EVT_OVERRUN : `HBWE_EVT_DATA_WRITE;
        s_d.rx_pulses = 4'b0011; // status update, packet discard
      end else if (rx_ctx_sel == HBWE_RX_FILL && rx_fifo_overrun && !rx_bus_error) begin
        s_d.rx_pulses = 4'b0110; // back out, discard rest
      end else if (rx_bus_error && rx_ctx_sel <= HBWE_RX_FILL) begin
        s_d.ctx[rx_ctx_sel].dead = 1'b1;
        s_d.ctx[rx_ctx_sel].event_code = `HBWE_EVT_DATA_WRITE;
        s_d.desc_ptr = rx_desc_addr;
        s_d.rx_pulses = 4'b1000; // flush whole context
      end
    end

    // Physical read response
    case (s_q.pr_st)
      HBWE_PR_IDLE: if (pr_start) begin
        s_d.pr_code = `HBWE_RESP_COMPLETE;
        s_d.pr_bus_err = 1'b0;
        s_d.pr_st = HBWE_PR_SENDING;
      end
      HBWE_PR_SENDING: begin
        if (pr_read_error && !pr_first_sent) begin
          s_d.pr_code = `HBWE_RESP_DATA_ERROR;
          s_d.pr_st = HBWE_PR_WAITACK;
        end else if (pr_read_error || pr_underrun) begin
          s_d.pr_stop = 1'b1; // truncate packet
          s_d.pr_bus_err = pr_read_error;
          s_d.pr_st = HBWE_PR_WAITACK;
        end else if (pr_ack_valid) begin
          s_d.pr_st = HBWE_PR_IDLE;
        end
      end
      HBWE_PR_WAITACK: if (pr_ack_valid) begin
        if (pr_ack_code == `HBWE_ACK_BUSY || pr_ack_code == `HBWE_ACK_DATA_ERROR) begin
          if (s_q.pr_bus_err) s_d.pr_code = `HBWE_RESP_DATA_ERROR;
          s_d.pr_st = HBWE_PR_SENDING; // retry
        end else begin
          s_d.pr_st = HBWE_PR_IDLE;
        end
      end
      default: s_d.pr_st = HBWE_PR_IDLE;
    endcase

    // Posted write acceptance
    if (pw_request) begin
      s_d.ack_v = 1'b1;
      if (s_q.posted_cnt + s_q.fail_cnt < QW'(QDEPTH)) begin
        s_d.ack_code = `HBWE_ACK_COMPLETE;
        s_d.posted_cnt = s_d.posted_cnt + 1'b1;
      end else begin
        s_d.ack_code = `HBWE_ACK_PENDING; // no posting when full
      end
    end
    if (pw_mem_done && s_q.posted_cnt != '0) begin
      s_d.posted_cnt = s_d.posted_cnt - 1'b1;
    end

    // Software clears the flag: drop head, advance queue
    if (avs_write && s_q.rd_done == 1'b0 && avs_address == `HBWE_OFS_EVCLR
        && avs_writedata[`HBWE_BIT_PWF] && avs_byteenable[0] && s_q.flag) begin
      s_d.flag = 1'b0;
      for (int i = 0; i < QDEPTH - 1; i++) begin
        s_d.queue[i] = s_q.queue[i+1];
      end
      s_d.queue[QDEPTH-1].valid = 1'b0;
      s_d.fail_cnt = s_q.fail_cnt - 1'b1;
    end
    if (avs_write && s_q.rd_done == 1'b0 && avs_address == `HBWE_OFS_CTXCLR) begin
      for (int c = 0; c < 3; c++) begin
        if (avs_writedata[c]) s_d.ctx[c] = '0;
      end
    end

    // Failed posted write enters queue tail
    if (pw_mem_error && s_q.posted_cnt != '0) begin
      s_d.queue[s_d.fail_cnt].valid = 1'b1;
      s_d.queue[s_d.fail_cnt].requester_bus_node = pw_requester_bus_node;
      s_d.queue[s_d.fail_cnt].dest_offset = pw_dest_offset;
      s_d.fail_cnt = s_d.fail_cnt + 1'b1;
      s_d.posted_cnt = s_d.posted_cnt - 1'b1;
      s_d.drop = 1'b1; // free FIFO
    end

    // Present head entry; flag raised again while queue holds one
    if (!s_d.flag && s_d.queue[0].valid) begin
      s_d.flag = 1'b1;
      s_d.show_node = s_d.queue[0].requester_bus_node;
      s_d.show_offset = s_d.queue[0].dest_offset;
    end // empty queue keeps last shown values

    // Read path: one wait cycle, then data
    if (avs_read && !s_q.rd_done) begin
      s_d.rd_done = 1'b1;
      s_d.rdata = 32'h0;
      if (avs_address == `HBWE_OFS_FAIL_HI) begin
        s_d.rdata = {s_q.show_node, s_q.show_offset[47:32]};
      end else if (avs_address == `HBWE_OFS_FAIL_LO) begin
        s_d.rdata = s_q.show_offset[31:0];
      end else if (avs_address == `HBWE_OFS_EVENT) begin
        s_d.rdata = {31'h0, s_q.flag};
      end else if (avs_address == `HBWE_OFS_CTX) begin
        s_d.rdata = {8'h0, 2'b00, s_q.ctx[2].dead, s_q.ctx[2].event_code,
                     2'b00, s_q.ctx[1].dead, s_q.ctx[1].event_code,
                     2'b00, s_q.ctx[0].dead, s_q.ctx[0].event_code};
      end else if (avs_address == `HBWE_OFS_STATUS) begin
        s_d.rdata = {16'h0, 4'(s_q.fail_cnt), 4'(s_q.posted_cnt), 8'(QDEPTH)};
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else if (!rst_n) begin
      s_q <= '0;
      s_q.rst_sync <= {s_q.rst_sync[0], 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // Avalon-MM handshake: writes take one cycle, reads two
  assign avs_waitrequest = avs_read && !s_q.rd_done;
  assign avs_readdata = s_q.rdata;
  assign avs_response = (is_mapped(avs_address) ? 2'b00 : 2'b10);

  // Outputs
  assign sv_mem_start = (s_q.sv_st == HBWE_SV_WRITE);
  assign sv_load_packet = (s_q.sv_st == HBWE_SV_SEND);
  assign sv_event_code = s_q.sv_evt;
  assign sv_event_valid = s_q.sv_evt_v;
  assign descriptor_pointer_reg = s_q.desc_ptr;
  assign rx_flush_ctx = s_q.rx_pulses[3];
  assign rx_backout = s_q.rx_pulses[2];
  assign rx_flush_packet = s_q.rx_pulses[1] | s_q.rx_pulses[0];
  assign rx_update_status = s_q.rx_pulses[0];
  assign pr_send = (s_q.pr_st == HBWE_PR_SENDING);
  assign pr_stop_tx = s_q.pr_stop;
  assign pr_resp_code = s_q.pr_code;
  assign pw_ack_valid = s_q.ack_v;
  assign pw_ack_code = s_q.ack_code;
  assign pw_fifo_drop = s_q.drop;
  assign deferred_write_failure_flag = s_q.flag;

  a_flag_has_entry: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.flag |-> s_q.fail_cnt != '0) else $error("flag set with empty queue");
  a_queue_bound: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.fail_cnt + s_q.posted_cnt <= QW'(QDEPTH)) else $error("queue overcommitted");
  a_full_pending: assert property (@(posedge clk) disable iff (!rst_n)
    pw_request && (s_q.posted_cnt + s_q.fail_cnt == QW'(QDEPTH)) |=> pw_ack_code == `HBWE_ACK_PENDING)
    else $error("complete while full");
  a_load_after_write: assert property (@(posedge clk) disable iff (!rst_n)
    sv_load_packet |-> $past(s_q.sv_st) == HBWE_SV_WRITE && $past(sv_mem_done))
    else $error("packet load before store-value write");
  a_fault_flags: assert property (@(posedge clk) disable iff (!rst_n)
    pw_mem_error && s_q.posted_cnt != '0 |=> pw_fifo_drop ##0 deferred_write_failure_flag)
    else $error("fault not flagged");
  a_empty_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.fail_cnt == '0 |=> $stable(s_q.show_offset) || s_q.flag) else $error("values changed");
  a_halt_rx: assert property (@(posedge clk) disable iff (!rst_n)
    rx_bus_error && rx_ctx_sel == HBWE_RX_ASYNC |=> s_q.ctx[0].dead && rx_flush_ctx)
    else $error("async receive not halted");
  a_first_read_err: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.pr_st == HBWE_PR_SENDING && pr_read_error && !pr_first_sent |=> pr_resp_code == `HBWE_RESP_DATA_ERROR)
    else $error("no data-error response");

  // Clearing the flag retires exactly the head entry
  a_clear_retires: assert property (@(posedge clk) disable iff (!rst_n)
    avs_write && !s_q.rd_done && avs_address == `HBWE_OFS_EVCLR && avs_writedata[`HBWE_BIT_PWF]
    && avs_byteenable[0] && s_q.flag && !pw_mem_error |=> s_q.fail_cnt + 1'b1 == $past(s_q.fail_cnt))
    else $error("flag clear did not retire entry");
  // A further queued failure raises the flag again
  a_reflag_next: assert property (@(posedge clk) disable iff (!rst_n)
    avs_write && !s_q.rd_done && avs_address == `HBWE_OFS_EVCLR && avs_writedata[`HBWE_BIT_PWF]
    && avs_byteenable[0] && s_q.flag && s_q.fail_cnt > QW'(1) |=> deferred_write_failure_flag)
    else $error("next failure not flagged");
  // Shown values belong to the head entry while flagged
  a_head_shown: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.flag |-> s_q.show_offset == s_q.queue[0].dest_offset && s_q.show_node == s_q.queue[0].requester_bus_node)
    else $error("shown values not the head entry");
  // Every posted write request is answered next cycle
  a_ack_answer: assert property (@(posedge clk) disable iff (!rst_n)
    pw_request |=> pw_ack_valid)
    else $error("write request not acknowledged");
  // Room left in the queue gives a complete ack
  a_room_complete: assert property (@(posedge clk) disable iff (!rst_n)
    pw_request && (s_q.posted_cnt + s_q.fail_cnt < QW'(QDEPTH)) |=> pw_ack_code == `HBWE_ACK_COMPLETE)
    else $error("pending while queue has room");
  // Packet-per-buffer fault: status and discard, no back-out
  a_ppb_discard: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_bus_error || rx_fifo_overrun) && rx_ctx_sel == 2'd1
    |=> rx_flush_packet && rx_update_status && !rx_backout && !rx_flush_ctx)
    else $error("packet-per-buffer fault mishandled");
  // Buffer-fill overrun backs the packet out without status
  a_fill_backout: assert property (@(posedge clk) disable iff (!rst_n)
    rx_fifo_overrun && !rx_bus_error && rx_ctx_sel == 2'd2 |=> rx_backout && rx_flush_packet && !rx_update_status)
    else $error("buffer-fill overrun not backed out");
  // Buffer-fill bus error halts the context
  a_fill_halt: assert property (@(posedge clk) disable iff (!rst_n)
    rx_bus_error && rx_ctx_sel == 2'd2 && !avs_write
    |=> s_q.ctx[2].dead && s_q.ctx[2].event_code == `HBWE_EVT_DATA_WRITE && rx_flush_ctx)
    else $error("buffer-fill context not halted");
  // Halting faults keep the failing descriptor address
  a_ptr_kept: assert property (@(posedge clk) disable iff (!rst_n)
    rx_bus_error && (rx_ctx_sel == 2'd0 || rx_ctx_sel == 2'd2) |=> descriptor_pointer_reg == $past(rx_desc_addr))
    else $error("descriptor pointer not kept");
  // Read fault after partial send stops transmission
  a_trunc_stop: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.pr_st == HBWE_PR_SENDING && pr_read_error && pr_first_sent |=> pr_stop_tx && !pr_send)
    else $error("truncated response not stopped");
  // Busy ack after bus error retries as data error
  a_retry_error: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.pr_st == HBWE_PR_WAITACK && pr_ack_valid && pr_ack_code == `HBWE_ACK_BUSY && s_q.pr_bus_err
    |=> pr_send && pr_resp_code == `HBWE_RESP_DATA_ERROR)
    else $error("retry not changed to data error");
  // Store-value fault reports and skips the packet load
  a_sv_event: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.sv_st == HBWE_SV_WRITE && sv_mem_error
    |=> sv_event_valid && sv_event_code == `HBWE_EVT_DATA_WRITE && !sv_load_packet)
    else $error("store-value fault not reported");
  // One packet load per finished store-value write
  a_load_once: assert property (@(posedge clk) disable iff (!rst_n)
    sv_load_packet |=> !sv_load_packet)
    else $error("packet loaded twice");
  // Writes never wait on the register bus
  a_write_nowait: assert property (@(posedge clk) disable iff (!rst_n)
    avs_write |-> !avs_waitrequest)
    else $error("write held in wait");
  // Reads are answered after one wait cycle
  a_read_answer: assert property (@(posedge clk) disable iff (!rst_n)
    avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read not answered");
  // FIFO drop only follows a posted write fault
  a_drop_on_fault: assert property (@(posedge clk) disable iff (!rst_n)
    pw_fifo_drop |-> $past(pw_mem_error))
    else $error("drop without fault");
endmodule
`default_nettype wire

// ### dv/hbwe_mem_model.sv
// Behavioural host memory that finishes or faults each write after a fixed delay
`default_nettype none
module hbwe_mem_model #(
  parameter int LAT = 30
) (
  input  wire logic        clk,
  input  wire logic        start,
  input  wire logic        fail,
  input  wire logic [63:0] tag_in,
  output logic             done,
  output logic             err,
  output logic      [63:0] tag_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int          due_q[$];
  logic [64:0] job_q[$];
  logic        start_q = 1'b0;
  int          now     = 0;
  initial begin
    done = 1'b0;
    err = 1'b0;
    tag_out = '0;
  end
  // One job per rising start, answered strictly in request order
  always @(posedge clk) begin
    now <= now + 1;
    start_q <= start;
    done <= 1'b0;
    err <= 1'b0;
    tag_out <= ~tag_out; // Tag lines mean nothing outside an answer cycle, done or fault
    if (start && !start_q) begin
      due_q.push_back(now + LAT);
      job_q.push_back({fail, tag_in});
    end
    if (due_q.size() > 0 && due_q[0] <= now) begin
      err <= job_q[0][64];
      done <= !job_q[0][64];
      tag_out <= job_q[0][63:0];
      void'(due_q.pop_front());
      void'(job_q.pop_front());
    end
  end
endmodule
`default_nettype wire

// ### dv/hbwe_unit_tb.sv
// Self-checking bench for the host bus write error unit
`include "hbwe_params.svh"
`default_nettype none
module hbwe_unit_tb;
  import hbwe_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, arst_n = 1'b0, avs_read, avs_write, avs_waitrequest, sv_mem_done, sv_mem_error;
  logic        sv_mem_start, sv_load_packet, sv_event_valid, rx_bus_error, rx_fifo_overrun, rx_flush_ctx;
  logic        rx_flush_packet, rx_backout, rx_update_status, pr_start, pr_read_error, pr_underrun, pr_first_sent;
  logic        pr_ack_valid, pr_send, pr_stop_tx, pw_request, pw_mem_done, pw_mem_error, pw_ack_valid;
  logic        pw_fifo_drop, deferred_write_failure_flag, sv_request, sv_fail, pw_fail;
  logic [7:0]  avs_address, pls;
  logic [31:0] avs_writedata, avs_readdata, rx_desc_addr, descriptor_pointer_reg, d;
  logic [3:0]  avs_byteenable, pr_ack_code, pr_resp_code, pw_ack_code;
  logic [1:0]  avs_response, rx_ctx_sel, r;
  logic [4:0]  sv_event_code, ev_code;
  logic [15:0] pw_requester_bus_node, pw_node_tb;
  logic [47:0] pw_dest_offset, pw_off_tb;
  logic [63:0] pw_tag;
  logic [3:0]  acks[$];
  int          fails = 0, samples_checked = 0, n_drop = 0, n_load = 0, n_stop = 0, n_fc = 0, n_bk = 0, n_fp = 0;
  int          ev_seen = 0, n_us = 0, i, k;
  time         t_done = 0, t_load = 0;
  assign {pw_request, pr_ack_valid, pr_first_sent, pr_read_error, pr_start, rx_fifo_overrun, rx_bus_error,
          sv_request} = pls;
  assign {pw_requester_bus_node, pw_dest_offset} = pw_mem_error ? pw_tag : {pw_node_tb, pw_off_tb};
  hbwe_unit #(.QDEPTH(4)) dut_u (.*);
  hbwe_mem_model sv_mem_u (.clk(clk), .start(sv_mem_start), .fail(sv_fail), .tag_in(64'h0),
                           .done(sv_mem_done), .err(sv_mem_error), .tag_out());
  hbwe_mem_model pw_mem_u (.clk(clk), .start(pw_request), .fail(pw_fail), .tag_in({pw_node_tb, pw_off_tb}),
                           .done(pw_mem_done), .err(pw_mem_error), .tag_out(pw_tag));
  initial begin
    forever #20 clk = ~clk;
  end
  // Catch one-cycle pulses mid-cycle, where they are settled
  always @(negedge clk) begin
    if (pw_ack_valid) acks.push_back(pw_ack_code);
    if (sv_event_valid) ev_code <= sv_event_code;
    if (sv_mem_done) t_done <= $time;
    if (sv_load_packet) t_load <= $time;
    ev_seen += int'(sv_event_valid);
    n_drop += int'(pw_fifo_drop);
    n_load += int'(sv_load_packet);
    n_stop += int'(pr_stop_tx);
    n_fc += int'(rx_flush_ctx);
    n_bk += int'(rx_backout);
    n_fp += int'(rx_flush_packet);
    n_us += int'(rx_update_status);
  end
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= wd;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    d = avs_readdata;
    r = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 50) begin
      fails++;
      close_out();
    end
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    pls[b] <= 1'b1;
    @(posedge clk);
    pls[b] <= 1'b0;
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    close_out();
  end
  initial begin
    {avs_read, avs_write, avs_address, avs_writedata, pls, sv_fail, pw_fail, rx_ctx_sel, rx_desc_addr} = '0;
    {pr_underrun, pw_node_tb, pw_off_tb} = '0;
    avs_byteenable = 4'hf;
    pr_ack_code = `HBWE_ACK_BUSY;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("flag", deferred_write_failure_flag, 0);
    // Five posted writes, second and third fault in memory
    for (i = 0; i < 5; i++) begin
      @(posedge clk);
      pls[7] <= 1'b1;
      pw_fail <= (i == 1 || i == 2);
      pw_node_tb <= 16'h0a00 + 16'(i);
      pw_off_tb <= {16'h1000 + 16'(i), 32'h20000000 + 32'(i)};
      @(posedge clk);
      pls[7] <= 1'b0;
    end
    repeat (3) @(posedge clk);
    for (i = 0; i < 5; i++) chk("ack", acks[i], (i < 4) ? `HBWE_ACK_COMPLETE : `HBWE_ACK_PENDING);
    for (k = 0; k < 200 && n_drop < 2; k++) @(negedge clk);
    if (k == 200) begin
      fails++;
      close_out();
    end
    chk("drops", 64'(n_drop), 2);
    for (i = 1; i < 3; i++) begin
      chk("flag", deferred_write_failure_flag, 1);
      bus(0, `HBWE_OFS_FAIL_HI, 0);
      chk("hi", d, {16'h0a00 + 16'(i), 16'h1000 + 16'(i)});
      bus(0, `HBWE_OFS_FAIL_LO, 0);
      chk("lo", d, 32'h20000000 + 32'(i));
      bus(1, `HBWE_OFS_EVCLR, 32'h1);
      repeat (2) @(posedge clk);
    end
    chk("flag", deferred_write_failure_flag, 0);
    bus(1, `HBWE_OFS_FAIL_HI, 32'h0);
    bus(0, `HBWE_OFS_FAIL_HI, 0);
    chk("hi kept", d, {16'h0a02, 16'h1002});
    bus(0, 8'hfc, 0);
    chk("unmapped", {r, d}, {2'b10, 32'h0});
    pulse(7);
    repeat (3) @(posedge clk);
    chk("ack", acks[5], `HBWE_ACK_COMPLETE);
    // Store-value write, first clean, then faulting
    pulse(0);
    for (k = 0; k < 200 && n_load == 0; k++) @(negedge clk);
    if (k == 200) begin
      fails++;
      close_out();
    end
    chk("load after write", t_load > t_done && t_done > 0, 1);
    sv_fail <= 1'b1;
    pulse(0);
    for (k = 0; k < 200 && ev_seen == 0; k++) @(negedge clk);
    if (k == 200) begin
      fails++;
      close_out();
    end
    chk("sv event", ev_code, `HBWE_EVT_DATA_WRITE);
    // Receive faults: async, packet-per-buffer, fill overrun, fill bus error
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      rx_ctx_sel <= (i == 3) ? 2'd2 : 2'(i);
      rx_desc_addr <= 32'h40000000 + 32'(i * 16);
      pulse((i == 2) ? 2 : 1);
      repeat (3) @(posedge clk);
    end
    chk("pointer", descriptor_pointer_reg, 32'h40000030);
    chk("ctx flushes", 64'(n_fc), 2);
    chk("backout", 64'(n_bk), 1);
    chk("packet discard", 64'(n_fp), 2);
    chk("status update", 64'(n_us), 1);
    bus(0, `HBWE_OFS_CTX, 0);
    chk("ctx", d, 32'h00250525);
    // Physical reads: fault on first read, then after partial send
    pulse(3);
    pulse(4);
    repeat (3) @(posedge clk);
    chk("resp", pr_resp_code, `HBWE_RESP_DATA_ERROR);
    pr_ack_code <= `HBWE_ACK_COMPLETE;
    pulse(6);
    pulse(3);
    @(posedge clk);
    pls <= 8'h30; // Read fault with first part already sent
    @(posedge clk);
    pls <= 8'h00;
    repeat (3) @(posedge clk);
    chk("stop", 64'(n_stop), 1);
    chk("trunc resp", pr_resp_code, `HBWE_RESP_COMPLETE);
    pr_ack_code <= `HBWE_ACK_BUSY;
    pulse(6);
    repeat (3) @(posedge clk);
    chk("retry resp", pr_resp_code, `HBWE_RESP_DATA_ERROR);
    chk("retry send", pr_send, 1);
    // Underrun during send, first part not flagged sent, retries the same response
    pr_ack_code <= `HBWE_ACK_COMPLETE;
    pulse(6);
    pulse(3);
    @(posedge clk);
    pr_underrun <= 1'b1;
    @(posedge clk);
    pr_underrun <= 1'b0;
    pr_ack_code <= `HBWE_ACK_BUSY;
    pulse(6);
    repeat (3) @(posedge clk);
    chk("underrun resp", pr_resp_code, `HBWE_RESP_COMPLETE);
    chk("stops", 64'(n_stop), 2);
    close_out();
  end
endmodule
`default_nettype wire
